// [rtl/ipm_ctrl.sv]
`timescale 1ns/10ps

// ============================================================================
// Record buffer
module ipm_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             in_valid_in,
  output      logic             in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output      logic             out_valid_out,
  input  wire logic             out_ready_in,
  output      logic [WIDTH-1:0] out_data_out,
  // Fill level
  output      logic [$clog2(DEPTH):0] count_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  wire              push_w = in_valid_in && in_ready_out;
  wire              pop_w  = out_valid_out && out_ready_in;

  assign in_ready_out  = (cnt_r != (AW+1)'(DEPTH)) && !flush_in;
  assign out_valid_out = (cnt_r != '0) && !flush_in;
  assign out_data_out  = mem_r[rd_ptr_r];
  assign count_out     = cnt_r;

  always_ff @(posedge clk_in)
  begin
    if (push_w)
      mem_r[wr_ptr_r] <= in_data_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in || flush_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + AW'(push_w);
      rd_ptr_r <= rd_ptr_r + AW'(pop_w);
      cnt_r    <= cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
endmodule // ipm_fifo

module ipm_ctrl
  import ipm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Drive state from the power state machine
  input  wire logic        op_enabled_in,
  input  wire logic [7:0]  mode_select_in,
  input  wire logic [15:0] command_word_in,
  input  wire logic        vel_zero_in,
  // Object access port
  input  wire logic        obj_wr_in,
  input  wire logic        obj_rd_in,
  input  wire logic [15:0] obj_index_in,
  input  wire logic [7:0]  obj_sub_in,
  input  wire logic [31:0] obj_wdata_in,
  output      logic        obj_ready_out,
  output      logic [31:0] obj_rdata_out,
  output      logic        obj_rvalid_out,
  // Status
  output      logic [15:0] state_report_word_out,
  output      logic [15:0] interp_status_out,
  // Set-point stream to the position loop
  output      ipm_seg_t    seg_out,
  output      logic        seg_start_out,
  output      logic        motion_enable_out,
  output      logic        decel_req_out
);

  // ==========================================================================
  // Decode
  ipm_state_t  state_r;
  ipm_state_t  state_nxt;
  logic [15:0] type_r;
  logic [31:0] word_one_r;
  logic [31:0] word_two_r;
  logic [6:0]  cnt_exp_r;
  logic        cnt_err_r;
  logic        seg_busy_r;
  logic [15:0] seg_left_r;
  logic [31:0] base_r;
  logic        treached_r;
  logic        decel_r;
  logic        seg_start_r;
  ipm_seg_t    seg_r;

  wire in_mode_w   = (mode_select_in == IPM_MODE_CODE);
  wire enable_w    = command_word_in[IPM_CW_ENABLE];
  wire relative_w  = command_word_in[IPM_CW_RELATIVE];
  wire halt_w      = command_word_in[IPM_CW_HALT];
  wire stop_opt_w  = command_word_in[IPM_CW_STOPOPT];
  wire hit_type_w  = (obj_index_in == IPM_IDX_TYPE)
                     && (obj_sub_in == IPM_SUB_ZERO);
  wire hit_one_w   = (obj_index_in == IPM_IDX_REC)
                     && (obj_sub_in == IPM_SUB_ONE);
  wire hit_two_w   = (obj_index_in == IPM_IDX_REC)
                     && (obj_sub_in == IPM_SUB_TWO);
  wire hit_stat_w  = (obj_index_in == IPM_IDX_STAT)
                     && (obj_sub_in == IPM_SUB_ZERO);
  wire valid_typ_w = (obj_wdata_in[15:0] == IPM_TYPE_LIN)
                     || (obj_wdata_in[15:0] == IPM_TYPE_CUB);
  // Reserved codes are ignored so the buffer is never lost to a typo
  wire type_chg_w  = obj_wr_in && hit_type_w && valid_typ_w
                     && (state_r == IPM_INACT)
                     && (obj_wdata_in[15:0] != type_r);
  wire cubic_w     = (type_r == IPM_TYPE_CUB);
  wire fifo_rdy_w;
  // Word two completes a record; held off while the buffer is full
  wire push_w      = obj_wr_in && hit_two_w && fifo_rdy_w;

  // ==========================================================================
  // Buffer
  ipm_rec_t    push_rec_w;
  ipm_rec_t    pop_rec_w;
  logic        pop_valid_w;
  logic [4:0]  fifo_cnt_w;
  wire         run_ok_w = (state_r == IPM_ACTIVE) && !halt_w;
  wire         pop_w    = run_ok_w && !seg_busy_r && pop_valid_w;

  assign push_rec_w.word_one = word_one_r;
  assign push_rec_w.word_two = obj_wdata_in;

  ipm_fifo #(
    .WIDTH (IPM_REC_WIDTH),
    .DEPTH (IPM_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .flush_in      (type_chg_w),
    .in_valid_in   (obj_wr_in && hit_two_w),
    .in_ready_out  (fifo_rdy_w),
    .in_data_in    (push_rec_w),
    .out_valid_out (pop_valid_w),
    .out_ready_in  (pop_w),
    .out_data_out  (pop_rec_w),
    .count_out     (fifo_cnt_w)
  );

  assign obj_ready_out = !(obj_wr_in && hit_two_w) || fifo_rdy_w;

  // ==========================================================================
  // Record unpacking
  wire [31:0] w1_w = pop_rec_w.word_one;
  wire [31:0] w2_w = pop_rec_w.word_two;
  wire [31:0] lin_pos_w   = w1_w;
  wire [15:0] lin_ticks_w = w2_w[15:0];
  wire [23:0] cub_pos24_w = {w1_w[31:24], w1_w[15:0]};
  wire [31:0] cub_pos_w   = {{8{cub_pos24_w[23]}}, cub_pos24_w};
  wire [23:0] cub_vel_w   = {w2_w[15:8], w2_w[7:0], w1_w[23:16]};
  wire [15:0] cub_ticks_w = {7'h00, w2_w[24], w2_w[23:16]};
  wire [31:0] rec_pos_w   = cubic_w ? cub_pos_w : lin_pos_w;
  wire [15:0] rec_ticks_w = cubic_w ? cub_ticks_w : lin_ticks_w;
  // A zero-length segment would stall the walk, so it lasts one sample
  wire [15:0] ticks_w     = (rec_ticks_w == 16'h0000) ? IPM_MIN_TICKS
                                                      : rec_ticks_w;
  wire [31:0] target_w    = relative_w ? (base_r + rec_pos_w)
                                       : rec_pos_w;
  wire [6:0]  rx_cnt_w    = obj_wdata_in[31:IPM_CNT_LSB];

  // ==========================================================================
  // Internal state machine
  always_comb
  begin
    state_nxt = state_r;
    if (!op_enabled_in)
      state_nxt = IPM_NOSEL;
    else
    begin
      case (state_r)
        IPM_NOSEL:
          if (in_mode_w)
            state_nxt = IPM_INACT;
        IPM_INACT:
          if (!in_mode_w)
            state_nxt = IPM_NOSEL;
          else if (enable_w)
            state_nxt = IPM_ACTIVE;
        IPM_ACTIVE:
          if (!in_mode_w)
            state_nxt = IPM_NOSEL;
          else if (!enable_w)
            state_nxt = IPM_INACT;
        default:
          state_nxt = IPM_NOSEL;
      endcase
    end
  end

  // ==========================================================================
  // Segment execution
  wire leaving_w  = (state_r == IPM_ACTIVE) && (state_nxt != IPM_ACTIVE);
  wire abort_w    = (leaving_w && !stop_opt_w)
                    || (seg_busy_r && halt_w);
  // With stop option set the running segment ends on its own time
  wire seg_end_w  = seg_busy_r && (seg_left_r == IPM_MIN_TICKS);
  wire finished_w = (state_r == IPM_ACTIVE) && !seg_busy_r
                    && !pop_valid_w;
  wire treach_w   = halt_w ? vel_zero_in : finished_w;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_r     <= IPM_NOSEL;
      seg_busy_r  <= 1'b0;
      seg_left_r  <= 16'h0000;
      seg_start_r <= 1'b0;
      seg_r       <= '0;
      base_r      <= 32'h0000_0000;
      treached_r  <= 1'b0;
      decel_r     <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      seg_start_r <= pop_w;
      treached_r  <= treach_w;
      decel_r     <= abort_w || (halt_w && (state_r == IPM_ACTIVE));
      if (pop_w)
      begin
        seg_busy_r <= 1'b1;
        seg_left_r <= ticks_w;
        base_r     <= target_w;
        seg_r.pos  <= target_w;
        seg_r.vel  <= cubic_w ? cub_vel_w : 24'h00_0000;
        seg_r.ticks <= ticks_w;
        seg_r.cubic <= cubic_w;
      end
      else if (abort_w || seg_end_w)
      begin
        seg_busy_r <= 1'b0;
        seg_left_r <= 16'h0000;
      end
      else if (seg_busy_r)
        seg_left_r <= seg_left_r - IPM_MIN_TICKS;
    end
  end

  // ==========================================================================
  // Object storage and integrity check
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      type_r     <= IPM_TYPE_RST;
      word_one_r <= 32'h0000_0000;
      word_two_r <= 32'h0000_0000;
      cnt_exp_r  <= 7'h00;
      cnt_err_r  <= 1'b0;
    end
    else
    begin
      if (type_chg_w)
      begin
        type_r    <= obj_wdata_in[15:0];
        cnt_exp_r <= 7'h00;
        cnt_err_r <= 1'b0;
      end
      if (obj_wr_in && hit_one_w)
        word_one_r <= obj_wdata_in;
      if (push_w)
      begin
        word_two_r <= obj_wdata_in;
        // Resync to the host so one lost point flags once, not forever
        cnt_exp_r  <= rx_cnt_w + 7'h01;
        if (rx_cnt_w != cnt_exp_r)
          cnt_err_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Status and read-back
  wire fifo_empty_w = (fifo_cnt_w == 5'h00);
  wire fifo_low_w   = (fifo_cnt_w <= IPM_LOW_LIMIT);
  wire fifo_full_w  = !fifo_rdy_w && !type_chg_w;
  logic [15:0] istat_w;
  logic [31:0] rdata_w;

  always_comb
  begin
    istat_w                = 16'h0000;
    istat_w[IPM_IS_EMPTY]  = fifo_empty_w;
    istat_w[IPM_IS_LOW]    = fifo_low_w;
    istat_w[IPM_IS_FULL]   = fifo_full_w;
    istat_w[IPM_IS_CNTERR] = cnt_err_r;
  end

  assign rdata_w = hit_type_w ? {16'h0000, type_r} :
                   hit_one_w  ? word_one_r :
                   hit_two_w  ? word_two_r :
                   hit_stat_w ? {16'h0000, istat_w} : 32'h0000_0000;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      obj_rdata_out         <= 32'h0000_0000;
      obj_rvalid_out        <= 1'b0;
      state_report_word_out <= 16'h0000;
      interp_status_out     <= IPM_ISTAT_RST;
    end
    else
    begin
      obj_rvalid_out <= obj_rd_in;
      if (obj_rd_in)
        obj_rdata_out <= rdata_w;
      state_report_word_out                  <= 16'h0000;
      state_report_word_out[IPM_SW_RUNNING]  <= (state_r == IPM_ACTIVE);
      state_report_word_out[IPM_SW_TREACHED] <= treached_r;
      interp_status_out                      <= istat_w;
    end
  end

  // ==========================================================================
  // Set-point outputs; outside the active state motion stays enabled only while a segment left under the stop option, or popped in the leaving cycle, runs out
  assign seg_out           = seg_r;
  assign seg_start_out     = seg_start_r;
  assign motion_enable_out = seg_busy_r;
  assign decel_req_out     = decel_r;

endmodule // ipm_ctrl

// [common/ipm_pkg.sv]
package ipm_pkg;

  // ==========================================================================
  // Object indexes and sub-indexes
  localparam logic [15:0] IPM_IDX_TYPE  = 16'h60C0;
  localparam logic [15:0] IPM_IDX_REC   = 16'h60C1;
  localparam logic [15:0] IPM_IDX_STAT  = 16'h2072;
  localparam logic [7:0]  IPM_SUB_ZERO  = 8'h00;
  localparam logic [7:0]  IPM_SUB_ONE   = 8'h01;
  localparam logic [7:0]  IPM_SUB_TWO   = 8'h02;

  // ==========================================================================
  // Operating mode code and interpolation type codes
  localparam logic [7:0]  IPM_MODE_CODE = 8'h07;
  localparam logic [15:0] IPM_TYPE_LIN  = 16'h0000;
  localparam logic [15:0] IPM_TYPE_CUB  = 16'hFFFF;
  localparam logic [15:0] IPM_TYPE_RST  = 16'h0000;

  // ==========================================================================
  // Command word, state report word, interpolation status and record point counter bit positions
  localparam int IPM_CW_ENABLE   = 4;
  localparam int IPM_CW_RELATIVE = 6;
  localparam int IPM_CW_HALT     = 8;
  localparam int IPM_CW_STOPOPT  = 11;
  localparam int IPM_SW_TREACHED = 10;
  localparam int IPM_SW_RUNNING  = 12;
  localparam int IPM_IS_EMPTY    = 15;
  localparam int IPM_IS_LOW      = 14;
  localparam int IPM_IS_FULL     = 13;
  localparam int IPM_IS_CNTERR   = 12;
  localparam int IPM_CNT_LSB     = 25;

  // ==========================================================================
  // Buffer geometry
  localparam int          IPM_FIFO_DEPTH = 16;
  localparam int          IPM_REC_WIDTH  = 64;
  localparam logic [4:0]  IPM_LOW_LIMIT  = 5'h04;
  localparam logic [15:0] IPM_MIN_TICKS  = 16'h0001;
  // An empty buffer is also at or below the low limit
  localparam logic [15:0] IPM_ISTAT_RST  = 16'hC000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [31:0] word_two;
    logic [31:0] word_one;
  } ipm_rec_t;

  typedef struct packed {
    logic [31:0] pos;
    logic [23:0] vel;
    logic [15:0] ticks;
    logic        cubic;
  } ipm_seg_t;

  typedef enum logic [1:0] {
    IPM_NOSEL,
    IPM_INACT,
    IPM_ACTIVE
  } ipm_state_t;

endpackage

// [sim/ipm_ctrl_props.sv]
`timescale 1ns/10ps
// ==========================
// Mode and stream checks
module ipm_ctrl_chk
  import ipm_pkg::*;
(
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // Watched ports
  input wire logic        op_enabled_in,
  input wire logic [7:0]  mode_select_in,
  input wire logic [15:0] command_word_in,
  input wire logic        obj_wr_in,
  input wire logic        obj_rd_in,
  input wire logic [7:0]  obj_sub_in,
  input wire logic        obj_ready_out,
  input wire logic        obj_rvalid_out,
  input wire logic [15:0] state_report_word_out,
  input wire logic [15:0] interp_status_out,
  input wire logic        seg_start_out,
  input wire logic        motion_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire en = op_enabled_in && mode_select_in == IPM_MODE_CODE;
  wire run = state_report_word_out[IPM_SW_RUNNING];
  wire cw4 = command_word_in[IPM_CW_ENABLE];

  chk_enable_runs: assert property ((en && cw4) [*4] |-> run)
    else $error("running flag not set");
  chk_bit4_clear: assert property (!cw4 [*2] |=> !run)
    else $error("running flag kept");
  chk_other_mode: assert property (
    (mode_select_in != IPM_MODE_CODE) [*2] |=> !run)
    else $error("running in other mode");
  chk_not_enabled: assert property (!op_enabled_in [*2] |=> !run)
    else $error("running while disabled");
  chk_no_motion: assert property (!cw4 [*4] |-> !seg_start_out)
    else $error("segment started while inactive");
  chk_halt_stops: assert property (
    command_word_in[IPM_CW_HALT] [*3] |-> !motion_enable_out)
    else $error("motion under halt");
  chk_seg_motion: assert property (
    $rose(motion_enable_out) |-> seg_start_out)
    else $error("motion without segment start");
  chk_read_answer: assert property (obj_rd_in |=> obj_rvalid_out)
    else $error("read not answered");
  chk_ready_full: assert property (
    !obj_ready_out |-> obj_wr_in && obj_sub_in == IPM_SUB_TWO)
    else $error("ready low without record write");
  chk_level_flags: assert property (
    interp_status_out[IPM_IS_FULL]
    |-> !interp_status_out[IPM_IS_EMPTY]
        && !interp_status_out[IPM_IS_LOW])
    else $error("buffer flags disagree");
endmodule // ipm_ctrl_chk

bind ipm_ctrl ipm_ctrl_chk u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .op_enabled_in(op_enabled_in),
  .mode_select_in(mode_select_in), .command_word_in(command_word_in),
  .obj_wr_in(obj_wr_in), .obj_rd_in(obj_rd_in), .obj_sub_in(obj_sub_in),
  .obj_ready_out(obj_ready_out), .obj_rvalid_out(obj_rvalid_out),
  .state_report_word_out(state_report_word_out),
  .interp_status_out(interp_status_out), .seg_start_out(seg_start_out),
  .motion_enable_out(motion_enable_out)
);

// [sim/ipm_host.sv]
`timescale 1ns/10ps
// ==========================
// Host streaming model
module ipm_host
  import ipm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        ready_in,
  output      logic        wr_out,
  output      logic        rd_out,
  output      logic [15:0] index_out,
  output      logic [7:0]  sub_out,
  output      logic [31:0] wdata_out
);
  logic [6:0] cnt_r;

  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    index_out = 16'h0000;
    sub_out = 8'h00;
    wdata_out = 32'h0;
    cnt_r = 7'h00;
  end

  // Held until ready or for at most eight more cycles; released lines show the inverse, not the old value
  task automatic put(input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] dat, output logic ok);
    int n;
    n = 0;
    @(negedge clk_in);
    wr_out = 1'b1;
    index_out = idx;
    sub_out = sub;
    wdata_out = dat;
    // Ready also follows the lines set at the falling edge, so look at it just after them
    #1;
    while (ready_in !== 1'b1 && n < 8)
    begin
      n++;
      @(negedge clk_in);
      #1;
    end
    @(posedge clk_in);
    ok = (n < 8);
    @(negedge clk_in);
    wr_out = 1'b0;
    index_out = ~idx;
    sub_out = ~sub;
    wdata_out = ~dat;
  endtask

  task automatic get(input logic [15:0] idx, input logic [7:0] sub);
    @(negedge clk_in);
    rd_out = 1'b1;
    index_out = idx;
    sub_out = sub;
    @(negedge clk_in);
    rd_out = 1'b0;
    index_out = ~idx;
    sub_out = ~sub;
  endtask

  task automatic point(input logic [31:0] pos, input logic [15:0] tk,
                       output logic ok);
    put(IPM_IDX_REC, IPM_SUB_ONE, pos, ok);
    put(IPM_IDX_REC, IPM_SUB_TWO, {cnt_r, 9'h000, tk}, ok);
    if (ok)
      cnt_r = cnt_r + 7'h01;
  endtask
endmodule // ipm_host

// [sim/ipm_ctrl_bench.sv]
`timescale 1ns/10ps
module ipm_ctrl_bench
  import ipm_pkg::*;
();
  logic        clk_in, reset_in, op_en, vzero, ok;
  logic        wr, rd, rdy, rvalid, sstart, men, decel;
  logic [7:0]  mode, sub;
  logic [15:0] cw, idx, srw, ist;
  logic [31:0] wd, rdata, tgt, p;
  ipm_seg_t    seg;
  int          num_errors, compares, seed;
  logic [15:0] rd_q[$];
  ipm_seg_t    seg_q[$];

  ipm_ctrl uut (.clk_in(clk_in), .reset_in(reset_in),
    .op_enabled_in(op_en), .mode_select_in(mode), .command_word_in(cw),
    .vel_zero_in(vzero), .obj_wr_in(wr), .obj_rd_in(rd),
    .obj_index_in(idx), .obj_sub_in(sub), .obj_wdata_in(wd),
    .obj_ready_out(rdy), .obj_rdata_out(rdata), .obj_rvalid_out(rvalid),
    .state_report_word_out(srw), .interp_status_out(ist), .seg_out(seg),
    .seg_start_out(sstart), .motion_enable_out(men), .decel_req_out(decel));
  ipm_host host (.clk_in(clk_in), .ready_in(rdy), .wr_out(wr),
    .rd_out(rd), .index_out(idx), .sub_out(sub), .wdata_out(wd));

  // ==========================
  // Helpers
  task automatic check(input logic [72:0] got, input logic [72:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic rd_exp(input logic [15:0] i, input logic [15:0] e);
    rd_q.push_back(e);
    host.get(i, IPM_SUB_ZERO);
  endtask

  task automatic send(input logic [15:0] tk);
    p = $random(seed);
    tgt = cw[IPM_CW_RELATIVE] ? tgt + p : p;
    seg_q.push_back({tgt, 24'h00_0000, tk, 1'b0});
    host.point(p, tk, ok);
  endtask

  // Bounded: a stuck segment must not hang the run; four idle cycles in
  // a row, so a point still in flight is not taken for the end
  task automatic drain;
    int n;
    int idle;
    n = 0;
    idle = 0;
    while (idle < 4 && n < 400)
    begin
      n++;
      @(negedge clk_in);
      idle = (ist[IPM_IS_EMPTY] === 1'b1 && men === 1'b0) ? idle + 1 : 0;
    end
    check(idle >= 4, 1);
    check(seg_q.size(), 0);
  endtask

  // ==========================
  // Clock, monitor, watchdog
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(negedge clk_in)
  begin
    if (rvalid === 1'b1)
      check(rdata[15:0], rd_q.size() ? rd_q.pop_front() : 16'hX);
    if (sstart === 1'b1)
      check(seg, seg_q.size() ? seg_q.pop_front() : 73'hX);
  end

  initial
  begin
    #800000;
    num_errors++;
    finish_test;
  end

  // ==========================
  // Main sequence
  initial
  begin
    seed = 67005;
    num_errors = 0;
    compares = 0;
    tgt = 32'h0;
    reset_in = 1'b1;
    op_en = 1'b0;
    vzero = 1'b0;
    mode = 8'h00;
    cw = 16'h0000;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    check({16'h0000, IPM_ISTAT_RST}, {srw, ist});
    rd_exp(16'h1234, 16'h0000);
    host.put(IPM_IDX_TYPE, IPM_SUB_ZERO, 32'h0000FFFF, ok);
    rd_exp(IPM_IDX_TYPE, IPM_TYPE_RST);
    op_en = 1'b1;
    mode = IPM_MODE_CODE;
    repeat (2) @(negedge clk_in);
    host.put(IPM_IDX_TYPE, IPM_SUB_ZERO, 32'h0000FFFF, ok);
    host.put(IPM_IDX_TYPE, IPM_SUB_ZERO, 32'h00000005, ok);
    rd_exp(IPM_IDX_TYPE, IPM_TYPE_CUB);
    host.point(32'h00123456, 16'h0003, ok);
    repeat (2) @(negedge clk_in);
    check(ist[IPM_IS_EMPTY], 0);
    host.put(IPM_IDX_TYPE, IPM_SUB_ZERO, 32'h00000000, ok);
    host.cnt_r = 7'h00;
    repeat (2) @(negedge clk_in);
    check(ist, IPM_ISTAT_RST);
    // Absolute linear points loaded while inactive
    repeat (3) send(16'h0001 + 16'($unsigned($random(seed)) % 6));
    repeat (4) @(negedge clk_in);
    check(ist[15:12], 4'b0100);
    cw = 16'h0010;
    repeat (4) @(negedge clk_in);
    check(srw[IPM_SW_RUNNING], 1);
    repeat (2) send(16'h0002);
    drain;
    check(srw[IPM_SW_TREACHED], 1);
    cw = 16'h0050;
    repeat (3) send(16'h0001 + 16'($unsigned($random(seed)) % 4));
    drain;
    // Fill until refused, then drain
    cw = 16'h0040;
    repeat (3) @(negedge clk_in);
    check(srw[IPM_SW_RUNNING], 0);
    repeat (IPM_FIFO_DEPTH) send(16'h0001);
    repeat (2) @(negedge clk_in);
    check(ist[15:13], 3'b001);
    host.point(32'h0, 16'h0001, ok);
    check(ok, 0);
    cw = 16'h0050;
    drain;
    // Stop option: leaving active lets the running segment finish
    cw = 16'h0810;
    send(16'h0014);
    repeat (4) @(negedge clk_in);
    cw = 16'h0800;
    repeat (3) @(negedge clk_in);
    check({decel, men}, 2'b01);
    drain;
    // Halt in mid-segment
    cw = 16'h0010;
    send(16'h00C8);
    repeat (6) @(negedge clk_in);
    cw = 16'h0110;
    repeat (3) @(negedge clk_in);
    check({decel, men}, 2'b10);
    vzero = 1'b1;
    repeat (3) @(negedge clk_in);
    check(srw[IPM_SW_TREACHED], 1);
    // Counter slip, then cleared by a type change
    cw = 16'h0000;
    host.cnt_r = host.cnt_r + 7'h03;
    host.point(32'h0, 16'h0001, ok);
    repeat (2) @(negedge clk_in);
    check(ist[IPM_IS_CNTERR], 1);
    host.put(IPM_IDX_TYPE, IPM_SUB_ZERO, 32'h0000FFFF, ok);
    repeat (2) @(negedge clk_in);
    check(ist, IPM_ISTAT_RST);
    // Cubic point with a negative position, run to its end
    host.put(IPM_IDX_REC, IPM_SUB_ONE, 32'h9A223344, ok);
    seg_q.push_back({32'hFF9A3344, 24'hABCD22, 16'h0005, 1'b1});
    host.put(IPM_IDX_REC, IPM_SUB_TWO, 32'h0005ABCD, ok);
    cw = 16'h0010;
    drain;
    check(ist[IPM_IS_CNTERR], 0);
    mode = 8'h01;
    repeat (3) @(negedge clk_in);
    check(srw[IPM_SW_RUNNING], 0);
    finish_test;
  end
endmodule // ipm_ctrl_bench
